/* logic/iftm_top.sv */
/*
 * input terminal function map: seven filtered terminals, per-terminal
 * function select and active state, command outputs, trip latch, apb
 * register slave and one level interrupt.
 * assumes terminals are asynchronous to pclk and an apb master on pclk.
 */
module iftm_top
   import iftm_pkg::*;
#(
   parameter int unsigned STEP_CYCLES = IFTM_STEP_CYCLES // cycles per response step
) (
   input wire logic pclk, // apb clock, 100 mhz
   input wire logic presetn, // async reset, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb enable
   input wire logic pwrite, // apb direction
   input wire logic [7:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error, unmapped address
   input wire logic [IFTM_NUM_TERM-1:0] term_pin, // raw terminal levels
   output iftm_cmd_t cmd, // commands to motor control
   output logic irq // level interrupt
);

   // ----------------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------------
   logic [7:0] func_r [IFTM_NUM_TERM];
   logic [7:0] resp_r [IFTM_NUM_TERM];
   logic [IFTM_NUM_TERM-1:0] pol_r;
   logic [IFTM_NUM_TERM-1:0] filt;
   logic [IFTM_NUM_TERM-1:0] asserted;
   logic [IFTM_NUM_TERM-1:0] asserted_prev_r;
   logic [31:0] fn_act;
   logic [31:0] step_cnt_r;
   logic step_tick_r;
   logic refuse_r;
   logic [IFTM_NUM_EV-1:0] istat_r;
   logic [IFTM_NUM_EV-1:0] imask_r;
   logic [IFTM_NUM_EV-1:0] ev;
   logic trip_r;
   logic [7:0] trip_cnt_r;
   logic ext_prev_r;
   logic rst_prev_r;
   logic trip_set;
   logic trip_clr;
   logic sw_trip_clr;
   logic acc;
   logic wr_en;
   logic [31:0] rdata_nxt;
   logic addr_ok;
   iftm_cmd_t cmd_nxt;

   // ----------------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------------

   // supported option codes
   function automatic logic opt_ok(input logic [7:0] code);
      opt_ok = (code <= IFTM_OPT_RAMP2) || (code == IFTM_OPT_COAST) ||
               (code == IFTM_OPT_EXT) || (code == IFTM_OPT_RST);
   endfunction

   // mapped register offsets
   function automatic logic map_ok(input logic [7:0] a);
      map_ok = (a == IFTM_OFS_FUNC_LO) || (a == IFTM_OFS_FUNC_HI) ||
               (a == IFTM_OFS_POL) || (a == IFTM_OFS_RESP_LO) ||
               (a == IFTM_OFS_RESP_HI) || (a == IFTM_OFS_STATUS) ||
               (a == IFTM_OFS_ISTAT) || (a == IFTM_OFS_IMASK) ||
               (a == IFTM_OFS_TRIP);
   endfunction

   // ----------------------------------------------------------------------
   // apb handshake
   // ----------------------------------------------------------------------

   // one wait state: pready rises in the second access cycle
   assign acc = psel && penable;
   assign wr_en = acc && pready && pwrite;
   assign addr_ok = map_ok(paddr);

   // ready, error and read data registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else if (acc && !pready) begin
         pready <= 1'b1;
         pslverr <= !addr_ok;
         prdata <= pwrite ? 32'h0000_0000 : rdata_nxt;
      end else begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // terminal filters
   // ----------------------------------------------------------------------

   // shared response step prescaler
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         step_cnt_r <= 32'h0000_0000;
         step_tick_r <= 1'b0;
      end else if (step_cnt_r >= STEP_CYCLES - 1) begin
         step_cnt_r <= 32'h0000_0000;
         step_tick_r <= 1'b1;
      end else begin
         step_cnt_r <= step_cnt_r + 32'h0000_0001;
         step_tick_r <= 1'b0;
      end
   end

   // one filter per terminal
   generate
      for (genvar t = 0; t < IFTM_NUM_TERM; t++) begin : g_term
         iftm_term_filter u_filt (
            .pclk(pclk),
            .presetn(presetn),
            .pin(term_pin[t]),
            .tick(step_tick_r),
            .resp_time(resp_r[t]),
            .level(filt[t])
         );
      end
   endgenerate

   // active state conversion
   assign asserted = filt ^ pol_r;

   // ----------------------------------------------------------------------
   // configuration registers
   // ----------------------------------------------------------------------

   // function select and active state, with refusal of bad settings
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < 4; i++) begin
            func_r[i] <= IFTM_RST_FUNC_LO[i*IFTM_FLD_W +: IFTM_FLD_W];
         end
         for (int i = 4; i < IFTM_NUM_TERM; i++) begin
            func_r[i] <= IFTM_RST_FUNC_HI[(i-4)*IFTM_FLD_W +: IFTM_FLD_W];
         end
         pol_r <= IFTM_RST_POL;
         refuse_r <= 1'b0;
      end else begin
         refuse_r <= 1'b0;
         if (wr_en && (paddr == IFTM_OFS_FUNC_LO || paddr == IFTM_OFS_FUNC_HI)) begin
            for (int i = 0; i < IFTM_NUM_TERM; i++) begin
               if ((paddr == IFTM_OFS_FUNC_LO) == (i < 4)) begin
                  if (!opt_ok(pwdata[(i%4)*IFTM_FLD_W +: IFTM_FLD_W])) begin
                     refuse_r <= 1'b1;
                  end else begin
                     func_r[i] <= pwdata[(i%4)*IFTM_FLD_W +: IFTM_FLD_W];
                     if (pwdata[(i%4)*IFTM_FLD_W +: IFTM_FLD_W] == IFTM_OPT_RST && pol_r[i]) begin
                        pol_r[i] <= 1'b0;
                        refuse_r <= 1'b1;
                     end
                  end
               end
            end
         end
         if (wr_en && paddr == IFTM_OFS_POL) begin
            for (int i = 0; i < IFTM_NUM_TERM; i++) begin
               if (pwdata[i] && func_r[i] == IFTM_OPT_RST) begin
                  refuse_r <= 1'b1;
               end else begin
                  pol_r[i] <= pwdata[i];
               end
            end
         end
      end
   end

   // response times, values above the maximum are refused per field
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < IFTM_NUM_TERM; i++) begin
            resp_r[i] <= IFTM_RST_RESP;
         end
      end else if (wr_en && (paddr == IFTM_OFS_RESP_LO || paddr == IFTM_OFS_RESP_HI)) begin
         for (int i = 0; i < IFTM_NUM_TERM; i++) begin
            if ((paddr == IFTM_OFS_RESP_LO) == (i < 4) &&
                pwdata[(i%4)*IFTM_FLD_W +: IFTM_FLD_W] <= IFTM_RESP_MAX) begin
               resp_r[i] <= pwdata[(i%4)*IFTM_FLD_W +: IFTM_FLD_W];
            end
         end
      end
   end

   // ----------------------------------------------------------------------
   // function routing
   // ----------------------------------------------------------------------

   // or of all terminals per option code
   always_comb begin
      fn_act = 32'h0000_0000;
      for (int i = 0; i < IFTM_NUM_TERM; i++) begin
         if (func_r[i] < 8'h20) begin
            fn_act[func_r[i][4:0]] = fn_act[func_r[i][4:0]] | asserted[i];
         end
      end
   end

   // ----------------------------------------------------------------------
   // external trip latch
   // ----------------------------------------------------------------------
   assign trip_set = fn_act[IFTM_OPT_EXT[4:0]] && !ext_prev_r;
   assign sw_trip_clr = wr_en && paddr == IFTM_OFS_TRIP && pwdata[0];
   assign trip_clr = (fn_act[IFTM_OPT_RST[4:0]] && !rst_prev_r) || sw_trip_clr;

   // edge history of trip and reset functions
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_prev_r <= 1'b0;
         rst_prev_r <= 1'b0;
      end else begin
         ext_prev_r <= fn_act[IFTM_OPT_EXT[4:0]];
         rst_prev_r <= fn_act[IFTM_OPT_RST[4:0]];
      end
   end

   // trip flag, a new edge wins over a clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trip_r <= 1'b0;
      end else if (trip_set) begin
         trip_r <= 1'b1;
      end else if (trip_clr) begin
         trip_r <= 1'b0;
      end
   end

   // trip history, saturating, only device reset clears it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trip_cnt_r <= 8'h00;
      end else if (trip_set && trip_cnt_r != 8'hFF) begin
         trip_cnt_r <= trip_cnt_r + 8'h01;
      end
   end

   // ----------------------------------------------------------------------
   // command outputs
   // ----------------------------------------------------------------------

   // decode of the command bundle
   always_comb begin
      cmd_nxt = '0;
      cmd_nxt.trip = trip_r;
      cmd_nxt.error_code = trip_r ? IFTM_ERR_EXT : IFTM_ERR_NONE;
      cmd_nxt.coast_stop_cmd = fn_act[IFTM_OPT_COAST[4:0]] | trip_r;
      if (!cmd_nxt.coast_stop_cmd) begin
         cmd_nxt.forward_run_cmd = fn_act[IFTM_OPT_FWD[4:0]] & ~fn_act[IFTM_OPT_REV[4:0]];
         cmd_nxt.reverse_run_cmd = fn_act[IFTM_OPT_REV[4:0]] & ~fn_act[IFTM_OPT_FWD[4:0]];
         cmd_nxt.jog_cmd = fn_act[IFTM_OPT_JOG[4:0]];
      end
      cmd_nxt.run = cmd_nxt.forward_run_cmd | cmd_nxt.reverse_run_cmd | cmd_nxt.jog_cmd;
      cmd_nxt.speed_sel = {fn_act[IFTM_OPT_SPD3[4:0]], fn_act[IFTM_OPT_SPD2[4:0]],
                           fn_act[IFTM_OPT_SPD1[4:0]], fn_act[IFTM_OPT_SPD0[4:0]]};
      cmd_nxt.dc_brake_cmd = fn_act[IFTM_OPT_DCB[4:0]];
      cmd_nxt.motor2_select = fn_act[IFTM_OPT_MOT2[4:0]];
      cmd_nxt.second_ramp_select = fn_act[IFTM_OPT_RAMP2[4:0]];
   end

   // registered command bundle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmd <= '0;
      end else begin
         cmd <= cmd_nxt;
      end
   end

   // ----------------------------------------------------------------------
   // interrupts
   // ----------------------------------------------------------------------

   // terminal change history
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         asserted_prev_r <= '0;
      end else begin
         asserted_prev_r <= asserted;
      end
   end

   // event vector
   always_comb begin
      ev = '0;
      ev[IFTM_EV_TRIP] = trip_set;
      ev[IFTM_EV_REFUSE] = refuse_r;
      ev[IFTM_EV_CHANGE] = asserted != asserted_prev_r;
   end

   // sticky status, write one to clear, set wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         istat_r <= '0;
      end else if (wr_en && paddr == IFTM_OFS_ISTAT) begin
         istat_r <= (istat_r & ~pwdata[IFTM_NUM_EV-1:0]) | ev;
      end else begin
         istat_r <= istat_r | ev;
      end
   end

   // mask register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         imask_r <= '0;
      end else if (wr_en && paddr == IFTM_OFS_IMASK) begin
         imask_r <= pwdata[IFTM_NUM_EV-1:0];
      end
   end

   // interrupt line
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(istat_r & imask_r);
      end
   end

   // ----------------------------------------------------------------------
   // read mux
   // ----------------------------------------------------------------------
   always_comb begin
      rdata_nxt = 32'h0000_0000;
      unique case (paddr)
         IFTM_OFS_FUNC_LO: rdata_nxt = {func_r[3], func_r[2], func_r[1], func_r[0]};
         IFTM_OFS_FUNC_HI: rdata_nxt = {8'h00, func_r[6], func_r[5], func_r[4]};
         IFTM_OFS_POL: rdata_nxt[IFTM_NUM_TERM-1:0] = pol_r;
         IFTM_OFS_RESP_LO: rdata_nxt = {resp_r[3], resp_r[2], resp_r[1], resp_r[0]};
         IFTM_OFS_RESP_HI: rdata_nxt = {8'h00, resp_r[6], resp_r[5], resp_r[4]};
         IFTM_OFS_STATUS: begin
            rdata_nxt[IFTM_ST_TERM +: IFTM_NUM_TERM] = asserted;
            rdata_nxt[IFTM_ST_SPEED +: 4] = cmd.speed_sel;
            rdata_nxt[IFTM_ST_RUN] = cmd.run;
            rdata_nxt[IFTM_ST_TRIP] = trip_r;
            rdata_nxt[IFTM_ST_ERR +: 8] = cmd.error_code;
            rdata_nxt[IFTM_ST_CNT +: 8] = trip_cnt_r;
         end
         IFTM_OFS_ISTAT: rdata_nxt[IFTM_NUM_EV-1:0] = istat_r;
         IFTM_OFS_IMASK: rdata_nxt[IFTM_NUM_EV-1:0] = imask_r;
         IFTM_OFS_TRIP: rdata_nxt[0] = trip_r;
         default: rdata_nxt = 32'h0000_0000;
      endcase
   end

endmodule // iftm_top

/* logic/iftm_pkg.sv */
/*
 * package of the input terminal function map: register offsets, field
 * layout, reset values, option codes, timing counts and the command struct.
 * assumes a single 100 mhz clock domain and a 32-bit apb register bus.
 */
package iftm_pkg;

   // ----------------------------------------------------------------------
   // geometry
   // ----------------------------------------------------------------------
   localparam int unsigned IFTM_NUM_TERM = 7;

   // ----------------------------------------------------------------------
   // register byte offsets
   // ----------------------------------------------------------------------
   localparam logic [7:0] IFTM_OFS_FUNC_LO = 8'h00; // terminals 1..4 function select
   localparam logic [7:0] IFTM_OFS_FUNC_HI = 8'h04; // terminals 5..7 function select
   localparam logic [7:0] IFTM_OFS_POL = 8'h08; // per-terminal active state
   localparam logic [7:0] IFTM_OFS_RESP_LO = 8'h0C; // terminals 1..4 response time
   localparam logic [7:0] IFTM_OFS_RESP_HI = 8'h10; // terminals 5..7 response time
   localparam logic [7:0] IFTM_OFS_STATUS = 8'h14; // live state, read only
   localparam logic [7:0] IFTM_OFS_ISTAT = 8'h18; // sticky events, write one to clear
   localparam logic [7:0] IFTM_OFS_IMASK = 8'h1C; // event enables
   localparam logic [7:0] IFTM_OFS_TRIP = 8'h20; // bit 0 write one clears trip

   // ----------------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------------
   localparam int unsigned IFTM_FLD_W = 8; // byte per terminal field
   localparam int unsigned IFTM_ST_TERM = 0; // status [6:0] asserted terminals
   localparam int unsigned IFTM_ST_SPEED = 8; // status [11:8] speed index
   localparam int unsigned IFTM_ST_RUN = 12; // status run
   localparam int unsigned IFTM_ST_TRIP = 13; // status trip held
   localparam int unsigned IFTM_ST_ERR = 16; // status [23:16] error code
   localparam int unsigned IFTM_ST_CNT = 24; // status [31:24] trip history count
   localparam int unsigned IFTM_EV_TRIP = 0; // event: trip latched
   localparam int unsigned IFTM_EV_REFUSE = 1; // event: setting refused
   localparam int unsigned IFTM_EV_CHANGE = 2; // event: terminal state changed
   localparam int unsigned IFTM_NUM_EV = 3;

   // ----------------------------------------------------------------------
   // option codes
   // ----------------------------------------------------------------------
   localparam logic [7:0] IFTM_OPT_FWD = 8'h00;
   localparam logic [7:0] IFTM_OPT_REV = 8'h01;
   localparam logic [7:0] IFTM_OPT_SPD0 = 8'h02;
   localparam logic [7:0] IFTM_OPT_SPD1 = 8'h03;
   localparam logic [7:0] IFTM_OPT_SPD2 = 8'h04;
   localparam logic [7:0] IFTM_OPT_SPD3 = 8'h05;
   localparam logic [7:0] IFTM_OPT_JOG = 8'h06;
   localparam logic [7:0] IFTM_OPT_DCB = 8'h07;
   localparam logic [7:0] IFTM_OPT_MOT2 = 8'h08;
   localparam logic [7:0] IFTM_OPT_RAMP2 = 8'h09;
   localparam logic [7:0] IFTM_OPT_COAST = 8'h0B;
   localparam logic [7:0] IFTM_OPT_EXT = 8'h0C;
   localparam logic [7:0] IFTM_OPT_RST = 8'h12;

   // ----------------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------------
   localparam logic [31:0] IFTM_RST_FUNC_LO = 32'h120C_0100; // fwd, rev, trip, reset
   localparam logic [31:0] IFTM_RST_FUNC_HI = 32'h0006_0302; // bit0, bit1, jog
   localparam logic [6:0] IFTM_RST_POL = 7'h00; // all normally open
   localparam logic [7:0] IFTM_RST_RESP = 8'h01; // one step each
   localparam logic [7:0] IFTM_ERR_NONE = 8'h00;
   localparam logic [7:0] IFTM_ERR_EXT = 8'h0C; // external trip error code

   // ----------------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------------
   localparam int unsigned IFTM_CLK_HZ = 100_000_000;
   localparam int unsigned IFTM_STEP_MS = 2; // response time step
   localparam int unsigned IFTM_STEP_CYCLES = IFTM_CLK_HZ / 1000 * IFTM_STEP_MS;
   localparam logic [7:0] IFTM_RESP_MAX = 8'hC8; // 200 steps
   localparam logic [1:0] IFTM_PRIME_CYCLES = 2'h3; // filter bypass after reset

   // ----------------------------------------------------------------------
   // command bundle to the motor control
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic run; // any run request active
      logic forward_run_cmd; // run forward
      logic reverse_run_cmd; // run reverse
      logic jog_cmd; // run at jog frequency
      logic [3:0] speed_sel; // multi-speed index
      logic dc_brake_cmd; // dc braking on deceleration
      logic motor2_select; // second parameter set
      logic second_ramp_select; // second-stage ramps
      logic coast_stop_cmd; // output off, motor coasts
      logic trip; // trip held
      logic [7:0] error_code; // shown error
   } iftm_cmd_t;

endpackage

/* logic/iftm_term_filter.sv */
/*
 * one input terminal: two-flop synchroniser and response-time filter.
 * assumes a shared step tick from the parent and a response time in steps.
 */
module iftm_term_filter
   import iftm_pkg::*;
(
   input wire logic pclk, // system clock
   input wire logic presetn, // async reset, active low
   input wire logic pin, // raw terminal level
   input wire logic tick, // one pulse per response step
   input wire logic [7:0] resp_time, // response time in steps
   output logic level // filtered level
);

   logic sync1_r;
   logic sync2_r;
   logic [7:0] cnt_r;
   logic [1:0] prime_r;

   // two-flop synchroniser
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
      end else begin
         sync1_r <= pin;
         sync2_r <= sync1_r;
      end
   end

   // response filter, bypassed while priming after reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         level <= 1'b0;
         cnt_r <= 8'h00;
         prime_r <= 2'h0;
      end else if (prime_r != IFTM_PRIME_CYCLES) begin
         prime_r <= prime_r + 2'h1;
         level <= sync2_r;
         cnt_r <= 8'h00;
      end else if (sync2_r == level) begin
         cnt_r <= 8'h00;
      end else if (cnt_r >= resp_time) begin
         level <= sync2_r;
         cnt_r <= 8'h00;
      end else if (tick) begin
         cnt_r <= cnt_r + 8'h01;
      end
   end

endmodule // iftm_term_filter

/* tb/iftm_asserts.sv */
/* port checker of the terminal map top.
   assumes a bind to iftm_top, one clock pclk and reset presetn. */
module iftm_asserts
   import iftm_pkg::*;
(
   input wire logic pclk, // clock
   input wire logic presetn, // reset, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb enable
   input wire logic pready, // apb ready
   input wire logic pslverr, // apb error
   input wire iftm_cmd_t cmd // commands
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   chk_dir_excl: assert property (!(cmd.forward_run_cmd && cmd.reverse_run_cmd))
      else $error("both directions");
   chk_coast_run: assert property (cmd.coast_stop_cmd |-> !cmd.run)
      else $error("run while coasting");
   chk_trip_code: assert property (cmd.trip |-> cmd.error_code == IFTM_ERR_EXT)
      else $error("trip code wrong");
   chk_idle_code: assert property (!cmd.trip |-> cmd.error_code == IFTM_ERR_NONE)
      else $error("stray error code");
   chk_trip_coast: assert property (cmd.trip |-> cmd.coast_stop_cmd)
      else $error("trip without coast");
   chk_run_src: assert property (cmd.run |-> (cmd.forward_run_cmd || cmd.reverse_run_cmd || cmd.jog_cmd))
      else $error("run without source");
   chk_ready_pulse: assert property (pready |=> !pready)
      else $error("ready too long");
   chk_ready_wait: assert property ($rose(penable) && psel |=> pready)
      else $error("ready late");
   chk_err_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
endmodule // iftm_asserts

/* tb/iftm_switch_model.sv */
/* switch contacts wired to the seven terminals.
   assumes the bench sets actuation and contact type after a rising edge. */
module iftm_switch_model
   import iftm_pkg::*;
(
   input wire logic [IFTM_NUM_TERM-1:0] act, // switch actuated
   input wire logic [IFTM_NUM_TERM-1:0] nc, // contact normally closed
   output logic [IFTM_NUM_TERM-1:0] term_pin // terminal levels
);
   // an actuated closed contact opens and the line goes low
   assign term_pin = act ^ nc;
endmodule // iftm_switch_model

/* tb/tb.sv */
/* self-checking bench of the terminal map: apb master, switches, checker.
   assumes STEP_CYCLES of 4 so response filtering stays short. */
module tb
   import iftm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, irq, e;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000, prdata, q;
   logic [6:0] act = 7'h00, nc = 7'h00, term_pin;
   iftm_cmd_t cmd;
   int n_fail = 0, compares = 0;
   // clock of 10 ns
   always #5 pclk = ~pclk;
   iftm_top #(.STEP_CYCLES(4)) uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .term_pin(term_pin), .cmd(cmd), .irq(irq));
   iftm_switch_model sw (.act(act), .nc(nc), .term_pin(term_pin));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   // one transfer, entered just after a rising edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // wait for ready at a rising edge, the watchdog bounds it
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // one idle edge so the next setup never reassigns psel in this step
      @(posedge pclk);
   endtask
   task automatic settle();
      repeat (40) @(posedge pclk);
   endtask
   task automatic t_reset();
      apb(1'b0, IFTM_OFS_FUNC_LO, '0);
      chk(q, IFTM_RST_FUNC_LO, "func lo");
      apb(1'b0, IFTM_OFS_FUNC_HI, '0);
      chk(q, IFTM_RST_FUNC_HI, "func hi");
      apb(1'b0, IFTM_OFS_POL, '0);
      chk(q, 32'h0000_0000, "pol");
      apb(1'b0, IFTM_OFS_RESP_LO, '0);
      chk(q, 32'h0101_0101, "resp");
      apb(1'b0, 8'h24, '0);
      chk(32'(e), 32'h0000_0001, "unmapped");
      $display("test reset done");
   endtask
   task automatic t_run();
      act <= 7'h01;
      settle();
      chk(32'({cmd.run, cmd.forward_run_cmd, cmd.reverse_run_cmd}), 32'h6, "fwd");
      act <= 7'h03;
      settle();
      chk(32'({cmd.run, cmd.forward_run_cmd, cmd.reverse_run_cmd}), 32'h0, "both");
      apb(1'b1, IFTM_OFS_POL, 32'h0000_0002);
      nc <= 7'h02;
      act <= 7'h00;
      settle();
      chk(32'({cmd.run, cmd.forward_run_cmd, cmd.reverse_run_cmd}), 32'h0, "nc idle");
      act <= 7'h02;
      settle();
      chk(32'({cmd.run, cmd.forward_run_cmd, cmd.reverse_run_cmd}), 32'h5, "rev nc");
      apb(1'b1, IFTM_OFS_POL, '0);
      nc <= 7'h00;
      act <= 7'h00;
      $display("test run done");
   endtask
   task automatic t_speed();
      apb(1'b1, IFTM_OFS_FUNC_LO, 32'h1203_0504);
      for (int i = 0; i < 16; i++) begin
         act <= {1'b0, i[1], i[0], 2'b00, i[3], i[2]};
         settle();
         chk(32'(cmd.speed_sel), 32'(i), "speed");
      end
      apb(1'b1, IFTM_OFS_FUNC_LO, IFTM_RST_FUNC_LO);
      act <= 7'h41;
      $display("test speed done");
   endtask
   task automatic t_codes();
      logic [7:0] code [4] = '{IFTM_OPT_DCB, IFTM_OPT_MOT2, IFTM_OPT_RAMP2, IFTM_OPT_COAST};
      for (int k = 0; k < 4; k++) begin
         apb(1'b1, IFTM_OFS_FUNC_HI, {8'h00, code[k], 16'h0302});
         settle();
         chk(32'({cmd.dc_brake_cmd, cmd.motor2_select, cmd.second_ramp_select, cmd.coast_stop_cmd, cmd.run}),
            32'({4'(4'b1000 >> k), k != 3}), "code");
      end
      act <= 7'h01;
      settle();
      chk(32'(cmd.run), 32'h1, "coast off");
      apb(1'b1, IFTM_OFS_FUNC_HI, 32'h0006_0306);
      act <= 7'h10;
      settle();
      chk(32'(cmd.jog_cmd), 32'h1, "jog or");
      act <= 7'h00;
      settle();
      chk(32'(cmd.jog_cmd), 32'h0, "jog off");
      apb(1'b1, IFTM_OFS_FUNC_HI, IFTM_RST_FUNC_HI);
      $display("test codes done");
   endtask
   task automatic t_trip();
      apb(1'b1, IFTM_OFS_IMASK, 32'h0000_0001);
      act <= 7'h04;
      settle();
      chk(32'({cmd.trip, cmd.error_code, irq}), 32'({1'b1, IFTM_ERR_EXT, 1'b1}), "trip");
      act <= 7'h00;
      settle();
      chk(32'(cmd.trip), 32'h1, "held");
      apb(1'b1, IFTM_OFS_ISTAT, 32'h0000_0001);
      apb(1'b1, IFTM_OFS_TRIP, 32'h0000_0001);
      settle();
      chk(32'({cmd.trip, cmd.error_code, irq}), 32'h0, "cleared");
      apb(1'b0, IFTM_OFS_STATUS, '0);
      chk(q, 32'h0000_0001 << IFTM_ST_CNT, "history kept");
      apb(1'b1, IFTM_OFS_POL, 32'h0000_0008);
      apb(1'b0, IFTM_OFS_POL, '0);
      chk(q, 32'h0000_0000, "nc refused");
      // mid-run reset wipes the trip history
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, IFTM_OFS_STATUS, '0);
      chk(q, 32'h0000_0000, "history reset");
      $display("test trip done");
   endtask
   task automatic end_of_test();
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // main sequence
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset();
      t_run();
      t_speed();
      t_codes();
      t_trip();
      end_of_test();
   end
   // watchdog
   initial begin
      repeat (5000) @(posedge pclk);
      n_fail++;
      end_of_test();
   end
endmodule // tb
bind iftm_top iftm_asserts chk_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pready(pready), .pslverr(pslverr), .cmd(cmd));
